// file: core/lpc_device.sv
// LED driver end: PWM counter, diagnostic capture, adjacent-pin check
`include "lpc_defs.svh"
module lpc_device import lpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  lpc_if.dev lnk,
  input wire logic [`LPC_NCH*8-1:0] i_pin_mv8,
  input wire logic [7:0] i_sense_mv8,
  input wire logic [`LPC_NCH-1:0] i_adjacent_fault,
  output logic [`LPC_NCH-1:0] o_channel_sink_pin,
  output logic [`LPC_NCH-1:0] o_pullup_en,
  output logic [11:0] o_count
);
  logic [`LPC_CFG_W-1:0] cfg_q;
  logic [`LPC_NCH*`LPC_GSW-1:0] duty_q;
  logic [`LPC_NCH*`LPC_GSW-1:0] pend_q;
  logic pend_valid_q;
  logic [11:0] cnt_q;
  lpc_state_t state_q;
  logic grayscale_clock_q;
  logic [`LPC_NCH-1:0] on_q;
  logic [`LPC_NCH-1:0] eo_q;
  logic [`LPC_NCH-1:0] es_q;
  logic [`LPC_NCH-1:0] lo_q;
  logic [`LPC_NCH-1:0] ls_q;
  logic [2:0] flag_q;
  logic [`LPC_NCH-1:0] aps_q;
  logic fault_q;
  logic [7:0] aps_cnt_q;
  logic aps_busy_q;
  logic [`LPC_NCH-1:0] det_open;
  logic [`LPC_NCH-1:0] det_short;

  // Edge detect on the grayscale clock, which arrives synchronous to i_clk
  wire gedge = lnk.grayscale_clock & ~grayscale_clock_q;
  wire cmd_gs = lnk.cmd_valid && lnk.cmd == `LPC_CMD_GS;
  wire cmd_cfg = lnk.cmd_valid && lnk.cmd == `LPC_CMD_CFG;
  wire cmd_aps = lnk.cmd_valid && lnk.cmd == `LPC_CMD_APS;
  wire cmd_clr = lnk.cmd_valid && lnk.cmd == `LPC_CMD_ERRCLR;
  wire [1:0] mode = cfg_q[`LPC_CFG_MODE_HI:`LPC_CFG_MODE_LO];
  // Last count of the cycle, also the late capture edge
  wire [11:0] cnt_max = (mode == LPC_MODE_8) ? `LPC_LATE_8 :
                        (mode == LPC_MODE_10) ? `LPC_LATE_10 : `LPC_LATE_12;
  wire running = state_q == LPC_ST_RUN;
  wire cycle_end = running && gedge && cnt_q == cnt_max;
  wire restart = cmd_gs && cfg_q[`LPC_CFG_TRESET] && lnk.blank;
  wire [11:0] cnt_inc = cnt_q + 12'h001;
  wire [11:0] early_edge = `LPC_EARLY_EDGE;

  lpc_detect u_det (
    .i_pin_mv8(i_pin_mv8),
    .i_sense_mv8(i_sense_mv8),
    .i_open_sel(cfg_q[`LPC_CFG_OPEN_SEL]),
    .i_short_sel(cfg_q[`LPC_CFG_SHORT_SEL]),
    .o_open(det_open),
    .o_short(det_short)
  );

  // Configuration word and duty latch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= '0;
      pend_q <= '0;
      pend_valid_q <= 1'b0;
      duty_q <= '0;
    end else begin
      if (cmd_cfg) cfg_q <= lnk.function_config_word;
      if (cmd_gs && !restart) begin
        pend_q <= lnk.duty_value;
        pend_valid_q <= 1'b1;
      end
      if (restart) begin
        duty_q <= lnk.duty_value;
        pend_valid_q <= 1'b0;
      end else if (pend_valid_q && (cycle_end || !running)) begin
        duty_q <= pend_q;
        // A write landing on the commit edge must stay pending, not be lost
        if (!cmd_gs) pend_valid_q <= 1'b0;
      end
    end
  end

  // Counter state machine; blank low clears, blank high runs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= LPC_ST_IDLE;
      cnt_q <= '0;
      grayscale_clock_q <= 1'b0;
    end else begin
      grayscale_clock_q <= lnk.grayscale_clock;
      if (!lnk.blank) begin
        state_q <= LPC_ST_IDLE;
        cnt_q <= '0;
      end else if (restart) begin
        state_q <= LPC_ST_RUN;
        cnt_q <= '0;
      end else begin
        case (state_q)
          LPC_ST_IDLE: state_q <= LPC_ST_RUN;
          LPC_ST_RUN: begin
            if (cycle_end) begin
              if (cfg_q[`LPC_CFG_REPEAT]) cnt_q <= '0;
              else state_q <= LPC_ST_HOLD;
            end else if (gedge) begin
              cnt_q <= cnt_inc;
            end
          end
          default: state_q <= LPC_ST_HOLD;
        endcase
      end
    end
  end

  // Per-channel output, on while running and count is below duty
  genvar g;
  generate
    for (g = 0; g < `LPC_NCH; g = g + 1) begin : g_out
      always_ff @(posedge i_clk) begin
        if (i_rst) on_q[g] <= 1'b0;
        else on_q[g] <= running && (cnt_q < duty_q[g*`LPC_GSW +: `LPC_GSW]);
      end
    end
  endgenerate

  // Result sets refresh once per cycle at fixed counts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      eo_q <= '0;
      es_q <= '0;
      lo_q <= '0;
      ls_q <= '0;
    end else if (running && gedge) begin
      if (cnt_inc == early_edge) begin
        eo_q <= det_open;
        es_q <= det_short;
      end
      if (cnt_inc == cnt_max) begin
        lo_q <= det_open;
        ls_q <= det_short;
      end
    end
  end

  // Adjacent-pin check: fixed settle time, then latch flag and result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_q <= `LPC_FLAG_RESET;
      aps_q <= '0;
      fault_q <= 1'b0;
      aps_cnt_q <= '0;
      aps_busy_q <= 1'b0;
    end else if (aps_busy_q) begin
      aps_cnt_q <= aps_cnt_q - 8'h01;
      if (aps_cnt_q == 8'h01) begin
        aps_busy_q <= 1'b0;
        aps_q <= i_adjacent_fault;
        if (|i_adjacent_fault) begin
          flag_q <= `LPC_FLAG_FAIL;
          fault_q <= 1'b1;
        end else begin
          flag_q <= `LPC_FLAG_PASS;
        end
      end
    end else if (cmd_aps) begin
      aps_busy_q <= 1'b1;
      aps_cnt_q <= `LPC_APS_CYCLES;
    end else if (cmd_clr && !(|i_adjacent_fault)) begin
      // Clear only once the short is gone, so a live fault keeps the pin low
      flag_q <= `LPC_FLAG_RESET;
      aps_q <= '0;
      fault_q <= 1'b0;
    end
  end

  assign o_channel_sink_pin = on_q;
  assign o_pullup_en = ~on_q;
  assign o_count = cnt_q;
  assign lnk.early_open = eo_q;
  assign lnk.early_short = es_q;
  assign lnk.late_open = lo_q;
  assign lnk.late_short = ls_q;
  assign lnk.adjacent_check_flag = flag_q;
  assign lnk.adjacent_short_result = aps_q;
  assign lnk.fault_n = ~fault_q;
  assign lnk.check_busy = aps_busy_q;
endmodule

// file: core/lpc_defs.svh
// Constants for the LED PWM cycle and diagnostics block
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH
`define LPC_NCH 24
`define LPC_GSW 12
`define LPC_EARLY_EDGE 12'h009
`define LPC_LATE_12 12'hfff
`define LPC_LATE_10 12'h3ff
`define LPC_LATE_8 12'h0ff
`define LPC_FLAG_PASS 3'h3
`define LPC_FLAG_FAIL 3'h6
`define LPC_FLAG_RESET 3'h0
`define LPC_CMD_W 3
`define LPC_CMD_NONE 3'h0
`define LPC_CMD_GS 3'h1
`define LPC_CMD_CFG 3'h2
`define LPC_CMD_APS 3'h3
`define LPC_CMD_ERRCLR 3'h4
`define LPC_CFG_W 6
`define LPC_CFG_REPEAT 0
`define LPC_CFG_TRESET 1
`define LPC_CFG_OPEN_SEL 2
`define LPC_CFG_SHORT_SEL 3
`define LPC_CFG_MODE_LO 4
`define LPC_CFG_MODE_HI 5
`define LPC_APS_CYCLES 8'h0a
`endif

// file: core/lpc_pkg.sv
// Types for the LED PWM cycle and diagnostics block
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_MODE_12 = 2'b00,
    LPC_MODE_10 = 2'b01,
    LPC_MODE_8 = 2'b10
  } lpc_mode_t;
  typedef enum logic [1:0] {
    LPC_ST_IDLE = 2'b00,
    LPC_ST_RUN = 2'b01,
    LPC_ST_HOLD = 2'b10
  } lpc_state_t;
endpackage

// file: core/lpc_if.sv
// Link between the host and the LED driver ends
`include "lpc_defs.svh"
interface lpc_if;
  logic grayscale_clock;
  logic blank;
  logic [`LPC_CMD_W-1:0] cmd;
  logic cmd_valid;
  logic [`LPC_NCH*`LPC_GSW-1:0] duty_value;
  logic [`LPC_CFG_W-1:0] function_config_word;
  logic [`LPC_NCH-1:0] early_open;
  logic [`LPC_NCH-1:0] early_short;
  logic [`LPC_NCH-1:0] late_open;
  logic [`LPC_NCH-1:0] late_short;
  logic [2:0] adjacent_check_flag;
  logic [`LPC_NCH-1:0] adjacent_short_result;
  logic fault_n;
  logic check_busy;
  modport dev (input grayscale_clock, blank, cmd, cmd_valid, duty_value, function_config_word,
    output early_open, early_short, late_open, late_short, adjacent_check_flag,
    adjacent_short_result, fault_n, check_busy);
  modport host (output grayscale_clock, blank, cmd, cmd_valid, duty_value, function_config_word,
    input early_open, early_short, late_open, late_short, adjacent_check_flag,
    adjacent_short_result, fault_n, check_busy);
endinterface

// file: core/lpc_detect.sv
// Per-channel open and short comparator with threshold selection
`include "lpc_defs.svh"
module lpc_detect import lpc_pkg::*; (
  input wire logic [`LPC_NCH*8-1:0] i_pin_mv8,
  input wire logic [7:0] i_sense_mv8,
  input wire logic i_open_sel,
  input wire logic i_short_sel,
  output logic [`LPC_NCH-1:0] o_open,
  output logic [`LPC_NCH-1:0] o_short
);
  // Voltages in 8-bit units of 0.1 V; low resolution is enough for thresholds
  logic [7:0] open_thr;
  logic [7:0] short_thr;
  assign open_thr = i_open_sel ? 8'h05 : 8'h03;
  assign short_thr = i_sense_mv8 - (i_short_sel ? 8'h07 : 8'h03);
  // One comparator pair per channel
  genvar g;
  generate
    for (g = 0; g < `LPC_NCH; g = g + 1) begin : g_ch
      assign o_open[g] = i_pin_mv8[g*8 +: 8] < open_thr;
      assign o_short[g] = i_pin_mv8[g*8 +: 8] > short_thr;
    end
  endgenerate
endmodule

// file: core/lpc_host.sv
// Host end: drives grayscale clock and commands, decodes diagnostics
`include "lpc_defs.svh"
module lpc_host import lpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  lpc_if.host lnk,
  input wire logic i_grayscale_clock_en,
  input wire logic i_blank,
  input wire logic [`LPC_CMD_W-1:0] i_cmd,
  input wire logic i_cmd_valid,
  input wire logic [`LPC_NCH*`LPC_GSW-1:0] i_duty,
  input wire logic [`LPC_CFG_W-1:0] i_cfg,
  output logic [`LPC_NCH-1:0] o_healthy,
  output logic [`LPC_NCH-1:0] o_open,
  output logic [`LPC_NCH-1:0] o_short,
  output logic [`LPC_NCH-1:0] o_gnd_short,
  output logic o_check_pass,
  output logic o_check_fail,
  output logic [`LPC_NCH-1:0] o_adjacent_result
);
  logic grayscale_clock_q;
  logic [`LPC_CMD_W-1:0] cmd_q;
  logic cmd_valid_q;
  logic [`LPC_NCH*`LPC_GSW-1:0] duty_q;
  logic [`LPC_CFG_W-1:0] cfg_q;
  logic [`LPC_NCH-1:0] ok_q;
  logic [`LPC_NCH-1:0] op_q;
  logic [`LPC_NCH-1:0] sh_q;
  logic [`LPC_NCH-1:0] gs_q;
  logic pass_q;
  logic fail_q;
  logic [`LPC_NCH-1:0] adj_q;

  // Grayscale clock: toggles at half rate when enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      grayscale_clock_q <= 1'b0;
      cmd_q <= `LPC_CMD_NONE;
      cmd_valid_q <= 1'b0;
      duty_q <= '0;
      cfg_q <= '0;
    end else begin
      grayscale_clock_q <= i_grayscale_clock_en & ~grayscale_clock_q;
      cmd_valid_q <= i_cmd_valid;
      cmd_q <= i_cmd;
      if (i_cmd_valid) begin
        duty_q <= i_duty;
        cfg_q <= i_cfg;
      end
    end
  end

  // Fault decoding from the four result bits; duty-caused patterns map to none
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ok_q <= '0;
      op_q <= '0;
      sh_q <= '0;
      gs_q <= '0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
      adj_q <= '0;
    end else begin
      ok_q <= ~lnk.early_open & ~lnk.early_short & ~lnk.late_open & lnk.late_short;
      op_q <= lnk.early_open & lnk.late_short & ~lnk.late_open;
      sh_q <= ~lnk.early_open & lnk.early_short & lnk.late_short;
      gs_q <= lnk.early_open & lnk.late_open & ~lnk.late_short;
      pass_q <= lnk.adjacent_check_flag == `LPC_FLAG_PASS;
      fail_q <= lnk.adjacent_check_flag == `LPC_FLAG_FAIL;
      adj_q <= lnk.adjacent_short_result;
    end
  end

  assign lnk.grayscale_clock = grayscale_clock_q;
  assign lnk.blank = i_blank;
  assign lnk.cmd = cmd_q;
  assign lnk.cmd_valid = cmd_valid_q;
  assign lnk.duty_value = duty_q;
  assign lnk.function_config_word = cfg_q;
  assign o_healthy = ok_q;
  assign o_open = op_q;
  assign o_short = sh_q;
  assign o_gnd_short = gs_q;
  assign o_check_pass = pass_q;
  assign o_check_fail = fail_q;
  assign o_adjacent_result = adj_q;
endmodule

// file: bench/lpc_checker.sv
// Concurrent checks on the link between the host and LED driver ends
`include "lpc_defs.svh"
module lpc_checker import lpc_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic blank,
  input wire logic [`LPC_CMD_W-1:0] cmd,
  input wire logic cmd_valid,
  input wire logic check_busy,
  input wire logic [2:0] adjacent_check_flag,
  input wire logic [`LPC_NCH-1:0] adjacent_short_result,
  input wire logic fault_n,
  input wire logic [`LPC_NCH-1:0] early_open,
  input wire logic [`LPC_NCH-1:0] late_short
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Decoded commands; clear is excluded where fault must hold
  wire logic is_aps = cmd_valid && cmd == `LPC_CMD_APS;
  wire logic is_clr = cmd_valid && cmd == `LPC_CMD_ERRCLR;
  // Busy as seen at the previous edge; its fall marks the end of a check
  logic busy_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) busy_q <= 1'b0;
    else busy_q <= check_busy;
  end
  wire logic done = busy_q && !check_busy;
  a_check_starts: assert property (is_aps && !check_busy |=> check_busy)
    else $error("check did not start");
  a_check_length: assert property ($rose(check_busy) |-> check_busy[*8] ##1 check_busy
    ##1 check_busy ##1 !check_busy)
    else $error("check length wrong");
  a_flag_legal: assert property (done |-> adjacent_check_flag inside {3'h3, 3'h6})
    else $error("check flag illegal");
  a_pass_clean: assert property (done && adjacent_check_flag == `LPC_FLAG_PASS
    |-> adjacent_short_result == 24'h0 && fault_n)
    else $error("pass with marks");
  a_fail_marks: assert property (done && adjacent_check_flag == `LPC_FLAG_FAIL
    |-> adjacent_short_result != 24'h0 && !fault_n)
    else $error("fail without marks");
  a_fault_holds: assert property (!fault_n && !is_clr |=> !fault_n)
    else $error("fault released early");
  a_result_steady: assert property (check_busy |-> $stable(adjacent_short_result))
    else $error("result moved while busy");
  a_flag_steady: assert property (!check_busy && !cmd_valid |=> $stable(adjacent_check_flag))
    else $error("flag moved without command");
  a_blank_freeze: assert property (!blank [*2] |=> $stable(early_open) && $stable(late_short))
    else $error("capture while blanked");
  // Main scenarios reached
  c_pass: cover property (done && adjacent_check_flag == `LPC_FLAG_PASS);
  c_fail: cover property (done && adjacent_check_flag == `LPC_FLAG_FAIL);
  c_capture: cover property (blank && $changed(early_open));
endmodule

// file: bench/tb_top.sv
// Self-checking bench joining the host and LED driver ends
`include "lpc_defs.svh"
module tb_top import lpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic gon = 1'b0;
  logic blank = 1'b0;
  logic cv = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [5:0] cfg = 6'h00;
  logic [287:0] duty = 288'h0;
  logic [191:0] pin = 192'h0;
  logic [7:0] sense = 8'h32;
  logic [23:0] af = 24'h0;
  logic [23:0] sink, pull, hh, ho, hs, hg, hr;
  logic [11:0] cnt, prev;
  logic hp, hf;
  int fails = 0;
  int n_tests = 0;
  int waited;
  int tbl[5] = '{2, 4, 20, 45, 49};
  // Free-running 50 MHz clock
  always #10 i_clk = ~i_clk;
  lpc_if u_lpc_if ();
  lpc_device u_lpc_device (.i_clk(i_clk), .i_rst(i_rst), .lnk(u_lpc_if.dev), .i_pin_mv8(pin),
    .i_sense_mv8(sense), .i_adjacent_fault(af), .o_channel_sink_pin(sink), .o_pullup_en(pull),
    .o_count(cnt));
  lpc_host u_lpc_host (.i_clk(i_clk), .i_rst(i_rst), .lnk(u_lpc_if.host), .i_grayscale_clock_en(gon),
    .i_blank(blank), .i_cmd(cmd), .i_cmd_valid(cv), .i_duty(duty), .i_cfg(cfg), .o_healthy(hh),
    .o_open(ho), .o_short(hs), .o_gnd_short(hg), .o_check_pass(hp), .o_check_fail(hf),
    .o_adjacent_result(hr));
  lpc_checker u_lpc_checker (.i_clk(i_clk), .i_rst(i_rst), .blank(u_lpc_if.blank),
    .cmd(u_lpc_if.cmd), .cmd_valid(u_lpc_if.cmd_valid), .check_busy(u_lpc_if.check_busy),
    .adjacent_check_flag(u_lpc_if.adjacent_check_flag), .fault_n(u_lpc_if.fault_n),
    .adjacent_short_result(u_lpc_if.adjacent_short_result), .early_open(u_lpc_if.early_open),
    .late_short(u_lpc_if.late_short));
  task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
    if (s !== e) begin
      $display("BAD %s exp %h got %h", nm, e, s);
      fails++;
    end
    n_tests++;
  endtask
  task automatic final_report();
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One command pulse, then let host and device registers settle
  task automatic send(logic [2:0] c);
    @(posedge i_clk);
    cmd <= c;
    cv <= 1'b1;
    @(posedge i_clk);
    cv <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  // Bounded wait for a counter value; a miss counts as a mismatch
  task automatic wait_cnt(logic [11:0] v);
    waited = 0;
    while (cnt !== v && waited < 9000) begin
      @(negedge i_clk);
      waited++;
    end
    chk("wait_cnt", 24'(cnt), 24'(v));
  endtask
  // Reference detector: open below, short above, strict compares
  function automatic logic [47:0] det(logic [5:0] f);
    for (int c = 0; c < 24; c++) begin
      det[c] = pin[c*8 +: 8] < (f[`LPC_CFG_OPEN_SEL] ? 8'h05 : 8'h03);
      det[24+c] = pin[c*8 +: 8] > sense - (f[`LPC_CFG_SHORT_SEL] ? 8'h07 : 8'h03);
    end
  endfunction
  function automatic logic [23:0] ons(logic [11:0] c);
    for (int i = 0; i < 24; i++) ons[i] = c < duty[i*12 +: 12];
  endfunction
  task automatic rand_pins();
    for (int c = 0; c < 24; c++) pin[c*8 +: 8] <= 8'(tbl[$urandom % 5]);
  endtask
  task automatic rand_duty();
    for (int c = 0; c < 24; c++) duty[c*12 +: 12] <= 12'($urandom % 32);
  endtask
  // Static pins: both sets equal the detector; host sees short or ground short
  task automatic sets(logic [5:0] f);
    logic [47:0] d;
    d = det(f);
    chk("early_open", u_lpc_if.early_open, d[23:0]);
    chk("early_short", u_lpc_if.early_short, d[47:24]);
    chk("late_open", u_lpc_if.late_open, d[23:0]);
    chk("late_short", u_lpc_if.late_short, d[47:24]);
    chk("host_short", hs, d[47:24]);
    chk("host_gnd", hg, d[23:0]);
    chk("host_ok_open", hh | ho, 24'h0);
  endtask
  task automatic adjacent_short_check(logic [2:0] c, logic [2:0] fl, logic [23:0] r);
    send(c);
    repeat (12) @(negedge i_clk);
    chk("flag", {21'h0, u_lpc_if.adjacent_check_flag}, {21'h0, fl});
    chk("result", u_lpc_if.adjacent_short_result, r);
    chk("host_result", hr, r);
    chk("fault_n", {23'h0, u_lpc_if.fault_n}, {23'h0, fl != `LPC_FLAG_FAIL});
    chk("host_flags", {22'h0, hp, hf}, {22'h0, fl == 3'h3, fl == 3'h6});
  endtask
  // Main sequence
  initial begin
    logic [5:0] cf;
    logic [23:0] v;
    int len;
    void'($urandom(59620));
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    gon <= 1'b1;
    // Single cycle in 8-bit mode under every threshold choice
    for (int m = 0; m < 4; m++) begin
      cf = {2'b10, 2'(m), 2'b00};
      @(posedge i_clk);
      rand_pins();
      cfg <= cf;
      send(`LPC_CMD_CFG);
      @(posedge i_clk);
      blank <= 1'b1;
      wait_cnt(12'h0ff);
      repeat (20) @(negedge i_clk);
      chk("hold_count", 24'(cnt), 24'h0000ff);
      chk("sinks_off", sink, 24'h0);
      chk("pullup", pull, ~sink);
      sets(cf);
      @(posedge i_clk);
      blank <= 1'b0;
      repeat (3) @(negedge i_clk);
      chk("blank_count", 24'(cnt), 24'h0);
    end
    // Auto repeat in 10-bit then 12-bit mode; pins change mid-run
    for (int i = 0; i < 2; i++) begin
      len = i ? 4096 : 1024;
      cf = {1'b0, ~i[0], 4'h1};
      @(posedge i_clk);
      blank <= 1'b0;
      cfg <= cf;
      send(`LPC_CMD_CFG);
      @(posedge i_clk);
      blank <= 1'b1;
      wait_cnt(12'h005);
      wait_cnt(12'h004);
      chk("period", 24'(waited), 24'(2 * len - 2));
      @(posedge i_clk);
      rand_pins();
      wait_cnt(12'h00c);
      wait_cnt(12'h00b);
      sets(cf);
    end
    // Duty compare, then duty writes without and with timing restart
    @(posedge i_clk);
    blank <= 1'b0;
    cfg <= 6'h21;
    rand_duty();
    send(`LPC_CMD_CFG);
    send(`LPC_CMD_GS);
    @(posedge i_clk);
    blank <= 1'b1;
    wait_cnt(12'h002);
    for (int i = 0; i < 40; i++) begin
      @(negedge i_clk);
      if (cnt === prev) chk("sink", sink, ons(cnt));
      if (cnt === prev) chk("pullup_run", pull, ~ons(cnt));
      prev = cnt;
    end
    @(posedge i_clk);
    duty <= {24{12'h0ff}};
    wait_cnt(12'h064);
    send(`LPC_CMD_GS);
    chk("no_restart", {23'h0, cnt > 12'h064}, 24'h1);
    chk("old_duty", sink, 24'h0);
    wait_cnt(12'h003);
    chk("new_duty", sink, 24'hffffff);
    @(posedge i_clk);
    cfg <= 6'h23;
    rand_duty();
    send(`LPC_CMD_CFG);
    wait_cnt(12'h064);
    send(`LPC_CMD_GS);
    chk("restart", {23'h0, cnt < 12'h008}, 24'h1);
    // Adjacent check: fail, refused clear, clear, pass
    v = 24'($urandom) | 24'h000001;
    @(posedge i_clk);
    blank <= 1'b0;
    af <= v;
    adjacent_short_check(`LPC_CMD_APS, `LPC_FLAG_FAIL, v);
    adjacent_short_check(`LPC_CMD_ERRCLR, `LPC_FLAG_FAIL, v);
    @(posedge i_clk);
    af <= 24'h0;
    adjacent_short_check(`LPC_CMD_ERRCLR, `LPC_FLAG_RESET, 24'h0);
    adjacent_short_check(`LPC_CMD_APS, `LPC_FLAG_PASS, 24'h0);
    final_report();
  end
  // Watchdog well past the expected run length
  initial begin
    #2000000;
    fails++;
    final_report();
  end
endmodule
